// >>> include/two_wire_params.svh
// Offsets, field positions, reset values and status codes of the
// two-wire slave; included by the design.
`ifndef TWO_WIRE_PARAMS_SVH
`define TWO_WIRE_PARAMS_SVH

`define CTRL_OFFSET 2'h0
`define STATUS_OFFSET 2'h1
`define DATA_OFFSET 2'h2
`define ADDRESS_OFFSET 2'h3

`define FLAG_BIT 7
`define ACK_ENABLE_BIT 6
`define START_REQUEST_BIT 5
`define STOP_REQUEST_BIT 4
`define ENABLE_BIT 2
`define GC_ENABLE_BIT 0

`define OWN_ADDRESS_RESET 8'h00
`define DATA_RESET 8'hff
`define GENERAL_CALL_ADDRESS 7'h00

`define ST_OWN_WRITE 8'h60
`define ST_ARB_OWN_WRITE 8'h68
`define ST_GC_WRITE 8'h70
`define ST_ARB_GC_WRITE 8'h78
`define ST_RX_ACK 8'h80
`define ST_RX_NACK 8'h88
`define ST_GC_RX_ACK 8'h90
`define ST_GC_RX_NACK 8'h98
`define ST_OWN_READ 8'ha8
`define ST_ARB_OWN_READ 8'hb0
`define ST_TX_ACK 8'hb8
`define ST_TX_NACK 8'hc0
`define ST_TX_LAST_ACK 8'hc8
`define ST_NO_INFO 8'hf8

`define BYTE_BITS 4'h8

`endif

// >>> include/two_wire_pkg.sv
// Types of the two-wire slave: bus phases and the state record.
// Assumes the params header is on the include path.
package two_wire_pkg;

  typedef enum logic [2:0] {
    idle_phase,
    addr_phase,
    addr_ack_phase,
    rx_phase,
    rx_ack_phase,
    tx_phase,
    tx_ack_phase,
    ignore_phase
  } phase_t;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    phase_t phase;
    logic [3:0] bit_count;
    logic [7:0] shift;
    logic [7:0] data;
    logic [7:0] own_address;
    logic [7:0] status_code;
    logic [1:0] prescaler;
    logic [7:0] read_data;
    logic flag;
    logic ack_enable;
    logic start_request;
    logic stop_request;
    logic enable;
    logic gc_hit;
    logic arb_lost;
    logic bus_busy;
    logic start_pending;
    logic start_issue;
    logic ack_latched;
    logic master_ack;
    logic sda_low;
    logic wake;
  } state_t;

endpackage

// >>> logic/two_wire_slave.sv
// Slave receive and transmit state handling of a two-wire serial unit.
// Assumes open-drain bus resolved outside, software on the plain
// register port, and a neighbouring master that reports lost arbitration.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "two_wire_params.svh"

module two_wire_slave
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic arb_lost_in,
  input wire logic deep_sleep,
  output logic wake_request,
  output logic start_issue
);

  two_wire_pkg::state_t cur;
  two_wire_pkg::state_t next_state;

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic own_match;
  logic gc_match;

  // Own or general call address compare against the received byte
  function automatic logic [1:0] address_match(
    input logic [7:0] received,
    input logic [7:0] own,
    input logic ack_en
  );
    logic [1:0] hit;
    hit = 2'h0;
    if (ack_en)
    begin
      hit[0] = (received[7:1] == own[7:1]);
      hit[1] = (received[7:1] == `GENERAL_CALL_ADDRESS) &&
               own[`GC_ENABLE_BIT];
    end
    return hit;
  endfunction

  assign scl = cur.scl_sync[1];
  assign sda = cur.sda_sync[1];
  assign scl_rise = scl && !cur.scl_prev;
  assign scl_fall = !scl && cur.scl_prev;
  assign start_seen = scl && cur.scl_prev && cur.sda_prev && !sda;
  assign stop_seen = scl && cur.scl_prev && !cur.sda_prev && sda;
  assign {gc_match, own_match} = address_match(cur.shift, cur.own_address,
                                               cur.ack_enable);

  always_comb
  begin
    next_state = cur;
    next_state.scl_sync = {cur.scl_sync[0], scl_in};
    next_state.sda_sync = {cur.sda_sync[0], sda_in};
    next_state.scl_prev = scl;
    next_state.sda_prev = sda;
    next_state.start_issue = 1'b0;

    // Software port; hardware events below take precedence
    if (reg_write)
    begin
      unique case (reg_addr)
        `CTRL_OFFSET:
        begin
          next_state.ack_enable = reg_wdata[`ACK_ENABLE_BIT];
          next_state.start_request = reg_wdata[`START_REQUEST_BIT];
          next_state.stop_request = reg_wdata[`STOP_REQUEST_BIT];
          next_state.enable = reg_wdata[`ENABLE_BIT];
          if (reg_wdata[`FLAG_BIT] && cur.flag)
          begin
            next_state.flag = 1'b0;
            next_state.wake = 1'b0;
            if (cur.phase == two_wire_pkg::tx_phase)
            begin
              next_state.shift = cur.data;
              next_state.sda_low = !cur.data[7];
              next_state.ack_latched = reg_wdata[`ACK_ENABLE_BIT];
            end
            if (reg_wdata[`START_REQUEST_BIT] &&
                (cur.phase == two_wire_pkg::ignore_phase ||
                 cur.phase == two_wire_pkg::idle_phase))
            begin
              next_state.phase = two_wire_pkg::idle_phase;
              next_state.start_pending = 1'b1;
            end
          end
          if (!reg_wdata[`ENABLE_BIT])
          begin
            next_state.phase = two_wire_pkg::idle_phase;
            next_state.sda_low = 1'b0;
          end
        end
        `STATUS_OFFSET: next_state.prescaler = reg_wdata[1:0];
        `DATA_OFFSET: next_state.data = reg_wdata;
        `ADDRESS_OFFSET: next_state.own_address = reg_wdata;
      endcase
    end

    if (reg_read)
    begin
      unique case (reg_addr)
        `CTRL_OFFSET:
        begin
          next_state.read_data = {cur.flag, cur.ack_enable,
                                  cur.start_request, cur.stop_request,
                                  1'b0, cur.enable, 2'h0};
        end
        `STATUS_OFFSET: next_state.read_data = {cur.status_code[7:3], 1'b0,
                                                cur.prescaler};
        `DATA_OFFSET: next_state.read_data = cur.data;
        `ADDRESS_OFFSET: next_state.read_data = cur.own_address;
      endcase
    end

    // Bus occupancy and lost arbitration tracking
    if (arb_lost_in)
    begin
      next_state.arb_lost = 1'b1;
    end
    if (start_seen)
    begin
      next_state.bus_busy = 1'b1;
    end
    if (stop_seen)
    begin
      next_state.bus_busy = 1'b0;
      next_state.arb_lost = 1'b0;
    end
    if (cur.start_pending && !cur.bus_busy && !cur.flag)
    begin
      next_state.start_issue = 1'b1;
      next_state.start_pending = 1'b0;
    end

    if (cur.enable && start_seen)
    begin
      next_state.phase = two_wire_pkg::addr_phase;
      next_state.bit_count = 4'h0;
      next_state.sda_low = 1'b0;
    end
    else if (cur.enable && stop_seen)
    begin
      next_state.phase = two_wire_pkg::idle_phase;
      next_state.sda_low = 1'b0;
    end
    else if (cur.enable)
    begin
      unique case (cur.phase)
        two_wire_pkg::idle_phase,
        two_wire_pkg::ignore_phase:
        begin
          next_state.sda_low = 1'b0;
        end
        two_wire_pkg::addr_phase:
        begin
          if (scl_rise)
          begin
            next_state.shift = {cur.shift[6:0], sda};
            next_state.bit_count = cur.bit_count + 4'h1;
          end
          if (scl_fall && cur.bit_count == `BYTE_BITS)
          begin
            if (own_match || gc_match)
            begin
              next_state.sda_low = 1'b1;
              next_state.gc_hit = gc_match && !own_match;
              next_state.phase = two_wire_pkg::addr_ack_phase;
            end
            else
            begin
              next_state.phase = two_wire_pkg::ignore_phase;
            end
          end
        end
        two_wire_pkg::addr_ack_phase:
        begin
          if (scl_fall)
          begin
            next_state.sda_low = 1'b0;
            next_state.flag = 1'b1;
            next_state.bit_count = 4'h0;
            next_state.wake = deep_sleep;
            if (cur.shift[0] && !cur.gc_hit)
            begin
              next_state.phase = two_wire_pkg::tx_phase;
              next_state.status_code = cur.arb_lost ?
                `ST_ARB_OWN_READ : `ST_OWN_READ;
            end
            else
            begin
              next_state.phase = two_wire_pkg::rx_phase;
              if (cur.gc_hit)
              begin
                next_state.status_code = cur.arb_lost ?
                  `ST_ARB_GC_WRITE : `ST_GC_WRITE;
              end
              else
              begin
                next_state.status_code = cur.arb_lost ?
                  `ST_ARB_OWN_WRITE : `ST_OWN_WRITE;
              end
            end
          end
        end
        two_wire_pkg::rx_phase:
        begin
          if (scl_rise)
          begin
            next_state.shift = {cur.shift[6:0], sda};
            next_state.bit_count = cur.bit_count + 4'h1;
          end
          if (scl_fall && cur.bit_count == `BYTE_BITS)
          begin
            if (!deep_sleep)
            begin
              next_state.data = cur.shift;
            end
            next_state.ack_latched = cur.ack_enable;
            next_state.sda_low = cur.ack_enable;
            next_state.phase = two_wire_pkg::rx_ack_phase;
          end
        end
        two_wire_pkg::rx_ack_phase:
        begin
          if (scl_fall)
          begin
            next_state.sda_low = 1'b0;
            next_state.flag = 1'b1;
            next_state.bit_count = 4'h0;
            if (cur.gc_hit)
            begin
              next_state.status_code = cur.ack_latched ?
                `ST_GC_RX_ACK : `ST_GC_RX_NACK;
            end
            else
            begin
              next_state.status_code = cur.ack_latched ?
                `ST_RX_ACK : `ST_RX_NACK;
            end
            next_state.phase = cur.ack_latched ?
              two_wire_pkg::rx_phase : two_wire_pkg::ignore_phase;
          end
        end
        two_wire_pkg::tx_phase:
        begin
          if (scl_rise)
          begin
            next_state.bit_count = cur.bit_count + 4'h1;
          end
          if (scl_fall && cur.bit_count == `BYTE_BITS)
          begin
            next_state.sda_low = 1'b0;
            next_state.phase = two_wire_pkg::tx_ack_phase;
          end
          else if (scl_fall && cur.bit_count != 4'h0)
          begin
            next_state.shift = {cur.shift[6:0], 1'b1};
            next_state.sda_low = !cur.shift[6];
          end
        end
        two_wire_pkg::tx_ack_phase:
        begin
          if (scl_rise)
          begin
            next_state.master_ack = !sda;
          end
          if (scl_fall)
          begin
            next_state.flag = 1'b1;
            next_state.bit_count = 4'h0;
            if (!cur.master_ack)
            begin
              next_state.status_code = `ST_TX_NACK;
              next_state.phase = two_wire_pkg::ignore_phase;
            end
            else if (cur.ack_latched)
            begin
              next_state.status_code = `ST_TX_ACK;
              next_state.phase = two_wire_pkg::tx_phase;
            end
            else
            begin
              next_state.status_code = `ST_TX_LAST_ACK;
              // Not addressed; released line gives ones
              next_state.phase = two_wire_pkg::ignore_phase;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cur <= '{
        scl_sync: 2'h3, sda_sync: 2'h3, scl_prev: 1'b1, sda_prev: 1'b1,
        phase: two_wire_pkg::idle_phase, bit_count: 4'h0, shift: 8'h00,
        data: `DATA_RESET, own_address: `OWN_ADDRESS_RESET,
        status_code: `ST_NO_INFO, prescaler: 2'h0, read_data: 8'h00,
        default: 1'b0
      };
    end
    else
    begin
      cur <= next_state;
    end
  end

  // Clock held low while an addressed transfer waits on software
  assign scl_oe_n = !(cur.flag && (cur.phase == two_wire_pkg::rx_phase ||
                      cur.phase == two_wire_pkg::tx_phase));
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign sda_oe_n = !cur.sda_low;
  assign reg_rdata = cur.read_data;
  assign wake_request = cur.wake;
  assign start_issue = cur.start_issue;

endmodule

// >>> bench/two_wire_checker.sv
// Port checker for the two-wire slave, bound onto its top module.
// Assumes scl_in and sda_in carry the resolved open-drain line levels.
`timescale 1ns/1ns

module two_wire_checker
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic scl_in,
  input wire logic scl_oe_n,
  input wire logic sda_in,
  input wire logic sda_oe_n,
  input wire logic deep_sleep,
  input wire logic wake_request,
  input wire logic start_issue
);
  logic clr_d1;
  logic clr_d2;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Remembers recent flag-clearing writes
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      clr_d1 <= 1'b0;
      clr_d2 <= 1'b0;
    end
    else
    begin
      clr_d1 <= reg_write && reg_addr == 2'h0 && reg_wdata[7];
      clr_d2 <= clr_d1;
    end
  end

  sequence start_gap;
    ##1 !start_issue ##1 !start_issue;
  endsequence

  AST_START_ONE: assert property ($rose(start_issue) |-> start_gap)
    else $error("start pulse longer than one cycle");
  AST_START_FREE: assert property (start_issue |-> scl_in && sda_in)
    else $error("start issued on a busy bus");
  AST_WAKE_CAUSE: assert property ($rose(wake_request) |-> $past(deep_sleep))
    else $error("wake without deep sleep");
  AST_WAKE_CLEAR: assert property ($fell(wake_request) |-> clr_d1 || clr_d2)
    else $error("wake dropped without flag clear");
  AST_SCL_FREE: assert property ($rose(scl_oe_n) |-> clr_d1 || clr_d2)
    else $error("clock released without flag clear");
  AST_SCL_GRAB: assert property ($fell(scl_oe_n) |-> !$past(scl_in))
    else $error("clock stretch began while high");
  AST_SDA_DRIVE: assert property ($fell(sda_oe_n) |-> !$past(scl_in))
    else $error("data driven while clock high");
  AST_SDA_FREE: assert property ($rose(sda_oe_n) |-> !$past(scl_in))
    else $error("data released while clock high");
  AST_SDA_STEADY: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
    else $error("data moved during clock high");
  AST_STATUS_GAP: assert property (reg_read && reg_addr == 2'h1 &&
    !scl_oe_n |=> !reg_rdata[2] && reg_rdata[7:3] != 5'h1f)
    else $error("status read while stretched not valid");
  AST_FLAG_STRETCH: assert property (reg_read && reg_addr == 2'h0 &&
    !scl_oe_n |=> reg_rdata[7])
    else $error("clock stretched while flag clear");
endmodule

bind two_wire_slave two_wire_checker chk (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .scl_in(scl_in),
  .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
  .deep_sleep(deep_sleep), .wake_request(wake_request),
  .start_issue(start_issue));

// >>> bench/two_wire_master_model.sv
// Bus master model driving the open-drain lines, 80 ns bit period.
// Assumes the bench resolves both lines with pull-ups.
`timescale 1ns/1ns

module two_wire_master_model
(
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_n,
  output logic sda_n
);
  initial
  begin
    scl_n = 1'b1;
    sda_n = 1'b1;
  end

  // Releases the clock and waits while the slave stretches it
  task automatic rise();
    int w;
    scl_n = 1'b1;
    for (w = 0; w < 5000 && scl_line !== 1'b1; w++)
      #4;
    #20;
  endtask

  task automatic pulse(output logic seen);
    rise();
    seen = sda_line;
    #20;
    scl_n = 1'b0;
    #20;
  endtask

  task automatic start_cond();
    #1;
    sda_n = 1'b1;
    rise();
    sda_n = 1'b0;
    #20;
    scl_n = 1'b0;
    #20;
  endtask

  task automatic stop_cond();
    #1;
    sda_n = 1'b0;
    #20;
    rise();
    sda_n = 1'b1;
    #40;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    #1;
    for (int i = 7; i >= 0; i--)
    begin
      sda_n = b[i];
      #20;
      pulse(seen);
    end
    sda_n = 1'b1;
    #20;
    pulse(seen);
    ack = ~seen;
    #20;
  endtask

  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic seen;
    #1;
    sda_n = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      #20;
      pulse(seen);
      b[i] = seen; // Released line reads as one
    end
    sda_n = ~ack;
    #20;
    pulse(seen);
    sda_n = 1'b1;
  endtask
endmodule

// >>> bench/test_two_wire_slave.sv
// Self-checking bench of the two-wire slave with a bus master model.
// Assumes design, checker and master model are compiled before it.
`timescale 1ns/1ns

module test_two_wire_slave;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic scl_oe_n;
  logic sda_oe_n;
  logic m_scl_n;
  logic m_sda_n;
  logic arb_lost_in = 1'b0;
  logic deep_sleep = 1'b0;
  logic wake_request;
  logic start_issue;
  wire logic scl_line = scl_oe_n & m_scl_n;
  wire logic sda_line = sda_oe_n & m_sda_n;
  int err_count = 0;
  int checks = 0;
  int n;
  logic ack;
  logic [7:0] v;
  logic [7:0] rx_code;
  logic [7:0] t_addr [4] = '{8'ha4, 8'ha4, 8'h00, 8'h00};
  logic t_arb [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic [7:0] t_code [4] = '{8'h60, 8'h68, 8'h70, 8'h78};

  always #2 clk = ~clk;

  two_wire_slave dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .scl_in(scl_line), .scl_out(),
    .scl_oe_n(scl_oe_n), .sda_in(sda_line), .sda_out(),
    .sda_oe_n(sda_oe_n), .arb_lost_in(arb_lost_in),
    .deep_sleep(deep_sleep), .wake_request(wake_request),
    .start_issue(start_issue));

  two_wire_master_model m (.scl_line(scl_line), .sda_line(sda_line),
    .scl_n(m_scl_n), .sda_n(m_sda_n));

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic check(input string what, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Status compared with the prescaler bits masked off
  task automatic expect_status(input logic [7:0] exp);
    rd(2'h1, v);
    check("status", v & 8'hf8, exp);
  endtask

  task automatic addr_try(input logic [7:0] a, input logic exp);
    m.start_cond();
    m.send_byte(a, ack);
    check("address ack", {7'h00, ack}, {7'h00, exp});
    if (exp)
      wr(2'h0, 8'hc4);
    m.stop_cond();
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #100000;
    err_count++;
    wrap_up();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    wr(2'h1, 8'h03);
    rd(2'h1, v);
    check("raw status", v, 8'hfb);
    wr(2'h3, 8'ha5);
    wr(2'h0, 8'h44);
    rd(2'h3, v);
    check("own address", v, 8'ha5);
    for (int i = 0; i < 4; i++)
    begin
      rx_code = (t_code[i] >= 8'h70) ? 8'h90 : 8'h80;
      m.start_cond();
      if (t_arb[i])
      begin
        @(posedge clk);
        arb_lost_in <= 1'b1;
        @(posedge clk);
        arb_lost_in <= 1'b0;
      end
      m.send_byte(t_addr[i], ack);
      check("address ack", {7'h00, ack}, 8'h01);
      check("stretch", {7'h00, scl_oe_n}, 8'h00);
      rd(2'h0, v);
      check("control", v, 8'hc4);
      expect_status(t_code[i]);
      wr(2'h0, 8'hc4);
      m.send_byte(t_code[i], ack);
      check("data ack", {7'h00, ack}, 8'h01);
      expect_status(rx_code);
      rd(2'h2, v);
      check("data", v, t_code[i]);
      wr(2'h0, 8'h84);
      m.send_byte(8'hc3, ack);
      check("data nack", {7'h00, ack}, 8'h00);
      expect_status(rx_code + 8'h08);
      wr(2'h0, 8'hc4);
      m.stop_cond();
      $display("test receive %0d done", i);
    end
    addr_try(8'h60, 1'b0);
    wr(2'h0, 8'h04);
    addr_try(8'ha4, 1'b0);
    wr(2'h0, 8'h44);
    addr_try(8'ha4, 1'b1);
    wr(2'h3, 8'ha4);
    addr_try(8'h00, 1'b0);
    $display("test address done");
    m.start_cond();
    m.send_byte(8'ha5, ack);
    expect_status(8'ha8);
    wr(2'h2, 8'h5a);
    wr(2'h0, 8'h84);
    m.recv_byte(1'b1, v);
    check("sent byte", v, 8'h5a);
    expect_status(8'hc8);
    m.recv_byte(1'b0, v);
    check("ones", v, 8'hff);
    m.stop_cond();
    wr(2'h0, 8'he4);
    for (n = 0; n < 40 && start_issue !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    check("start issue", {7'h00, start_issue}, 8'h01);
    wr(2'h0, 8'h44);
    addr_try(8'ha4, 1'b1);
    m.start_cond();
    m.send_byte(8'ha5, ack);
    expect_status(8'ha8);
    wr(2'h2, 8'h3c);
    wr(2'h0, 8'hc4);
    m.recv_byte(1'b1, v);
    check("more byte", v, 8'h3c);
    expect_status(8'hb8);
    wr(2'h2, 8'h96);
    wr(2'h0, 8'hc4);
    m.recv_byte(1'b0, v);
    check("final byte", v, 8'h96);
    expect_status(8'hc0);
    wr(2'h0, 8'hc4);
    m.stop_cond();
    $display("test transmit done");
    wr(2'h2, 8'h3c);
    @(posedge clk);
    deep_sleep <= 1'b1;
    m.start_cond();
    m.send_byte(8'ha4, ack);
    check("sleep ack", {7'h00, ack}, 8'h01);
    check("wake", {7'h00, wake_request}, 8'h01);
    check("sleep stretch", {7'h00, scl_oe_n}, 8'h00);
    wr(2'h0, 8'hc4);
    @(posedge clk);
    #1;
    check("wake clear", {7'h00, wake_request}, 8'h00);
    check("clock free", {7'h00, scl_oe_n}, 8'h01);
    m.send_byte(8'h11, ack);
    check("sleep data ack", {7'h00, ack}, 8'h01);
    rd(2'h2, v);
    check("sleep data", v, 8'h3c);
    @(posedge clk);
    deep_sleep <= 1'b0;
    wr(2'h0, 8'hc4);
    m.stop_cond();
    $display("test sleep done");
    wrap_up();
  end
endmodule
